// File: core/pwm_timing_config_pkg.sv
// Constants, register map and field layout for the modulator timing and configuration block.
package pwm_timing_config_pkg;

    // ------------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [23:0] CTL_ONE_IDX    = 24'hFFE381;
    localparam logic [23:0] DEAD_TIME_IDX  = 24'hFFE382;
    localparam logic [23:0] MIN_PULSE_IDX  = 24'hFFE383;
    localparam logic [23:0] CLK_SOURCE_IDX = 24'hFFE38D;
    localparam logic [23:0] STATUS_IDX     = 24'hFFE38E;

    localparam logic [31:0] CTL_ONE_ADDR    = {6'h00, CTL_ONE_IDX, 2'h0};
    localparam logic [31:0] DEAD_TIME_ADDR  = {6'h00, DEAD_TIME_IDX, 2'h0};
    localparam logic [31:0] MIN_PULSE_ADDR  = {6'h00, MIN_PULSE_IDX, 2'h0};
    localparam logic [31:0] CLK_SOURCE_ADDR = {6'h00, CLK_SOURCE_IDX, 2'h0};
    localparam logic [31:0] STATUS_ADDR     = {6'h00, STATUS_IDX, 2'h0};

    // ------------------------------------------------------------------
    // Field positions of the secondary modulator control register
    // ------------------------------------------------------------------
    localparam int RATE_LSB      = 6;
    localparam int INDEP_BIT     = 5;
    localparam int PAIR0_INV_BIT = 2;
    localparam int DIV_LSB       = 0;

    // ------------------------------------------------------------------
    // Reset values and the longest dead time
    // ------------------------------------------------------------------
    localparam logic [7:0] CTL_ONE_RST   = 8'h00;
    localparam logic [7:0] DEAD_TIME_RST = 8'h01;
    localparam logic [7:0] MIN_PULSE_RST = 8'h00;
    localparam logic [8:0] DEAD_TIME_MAX = 9'h100;

    // ------------------------------------------------------------------
    // Bus responses
    // ------------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Read state of the bus slave.
    typedef enum logic [1:0] {
        RD_IDLE = 2'h1,
        RD_RESP = 2'h2
    } rd_state_t;

endpackage

// File: core/pwm_timing_config.sv
// Timing shaping, dead time, pulse filter and configuration registers of the six-output modulator.
//
// Function
// - A reload event is produced every 1, 2, 4 or 8 periods for rate codes 00 to 11.
// - The reload rate is double-buffered and a new rate acts only when the running period ends.
// - Reads of the reload rate and divider fields return the holding value, not the working one.
// - With independent mode clear the outputs form three complementary pairs, else six independent channels.
// - Each pair has a polarity bit that inverts both of its outputs when set.
// - The divider divides the selected input clock by 1, 2, 4 or 8 for codes 00 to 11.
// - A written divider value reaches the counter only at a reload event that comes with values ready.
// - Dead time is an 8-bit count of undivided input clock ticks.
// - The smallest dead time is 1 and a value of 00h gives the longest dead time.
// - The dead time register takes only the first write after reset and ignores later ones.
// - During dead time both outputs of a complementary pair are deasserted.
// - The minimum pulse field sets the shortest high or low pulse in modulator clock ticks.
// - The effective minimum width is dead time plus minimum pulse, scaled by the working divider.
// - With values ready, the divider and external period and duty copies happen at the next reload.
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
module pwm_timing_config
    import pwm_timing_config_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst_b,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        external_modulator_clock_in,
    input  wire logic        period_end,
    input  wire logic        values_ready,
    input  wire logic [5:0]  duty_level,
    output logic [5:0]       pwm_out,
    output logic             reload_evt,
    output logic             load_working,
    output logic             prescale_tick,
    output logic [1:0]       working_divider
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic            awready_r, wready_r, bvalid_r, arready_r;
    logic [1:0]      bresp_r, rresp_r;
    logic [31:0]     rdata_r;
    logic            aw_got_r, w_got_r;
    logic [31:0]     awaddr_r, wdata_r;
    logic [3:0]      wstrb_r;
    rd_state_t       rd_state_r;
    logic [7:0]      ctl_hold_r, dt_r, mpf_r;
    logic            dt_locked_r, clk_src_r, ext_d_r;
    logic [1:0]      rate_work_r, div_work_r;
    logic [2:0]      rl_cnt_r, div_cnt_r;
    logic            reload_r, load_r, presc_r;
    logic [5:0]      filt_r, pwm_r;
    logic [12:0]     fcnt_r [6];
    logic            last_r [3];
    logic [8:0]      dcnt_r [3];

    // ------------------------------------------------------------------
    // Bus handshake decoding
    // ------------------------------------------------------------------
    wire        aw_hs      = s_axi_awvalid & awready_r;
    wire        w_hs       = s_axi_wvalid & wready_r;
    wire        b_hs       = bvalid_r & s_axi_bready;
    wire        ar_hs      = s_axi_arvalid & arready_r;
    wire        wr_fire    = (aw_got_r | aw_hs) & (w_got_r | w_hs) & ~bvalid_r;
    wire        bvalid_nxt = wr_fire | (bvalid_r & ~b_hs);
    wire        aw_got_nxt = ~wr_fire & (aw_got_r | aw_hs);
    wire        w_got_nxt  = ~wr_fire & (w_got_r | w_hs);
    wire        rvalid_nxt = ar_hs | ((rd_state_r == RD_RESP) & ~s_axi_rready);
    wire [31:0] wr_addr    = aw_got_r ? awaddr_r : s_axi_awaddr;
    wire [31:0] wr_data    = w_got_r ? wdata_r : s_axi_wdata;
    wire        wr_lane0   = w_got_r ? wstrb_r[0] : s_axi_wstrb[0];
    wire [7:0]  wr_byte    = wr_data[7:0];

    // Write address decoding; an unmapped or read-only target returns an error.
    wire wr_ctl  = wr_fire & (wr_addr == CTL_ONE_ADDR);
    wire wr_dt   = wr_fire & (wr_addr == DEAD_TIME_ADDR);
    wire wr_mpf  = wr_fire & (wr_addr == MIN_PULSE_ADDR);
    wire wr_src  = wr_fire & (wr_addr == CLK_SOURCE_ADDR);
    wire wr_ok   = wr_ctl | wr_dt | wr_mpf | wr_src;
    wire dt_take = wr_dt & wr_lane0 & ~dt_locked_r;

    // Read address decoding and data selection.
    wire        rd_ctl = s_axi_araddr == CTL_ONE_ADDR;
    wire        rd_dt  = s_axi_araddr == DEAD_TIME_ADDR;
    wire        rd_mpf = s_axi_araddr == MIN_PULSE_ADDR;
    wire        rd_src = s_axi_araddr == CLK_SOURCE_ADDR;
    wire        rd_sts = s_axi_araddr == STATUS_ADDR;
    wire        rd_ok  = rd_ctl | rd_dt | rd_mpf | rd_src | rd_sts;
    wire [7:0]  sts_byte = {dt_locked_r, rl_cnt_r, rate_work_r, div_work_r};
    wire [31:0] rd_word;
    assign rd_word = rd_ctl ? {24'h000000, ctl_hold_r} :
                     rd_dt  ? {24'h000000, dt_r} :
                     rd_mpf ? {24'h000000, mpf_r} :
                     rd_src ? {31'h00000000, clk_src_r} :
                     rd_sts ? {24'h000000, sts_byte} : 32'h00000000;

    // Write channel registers; awready and wready drop once their item is held.
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            awready_r <= 1'b0;
            wready_r  <= 1'b0;
            bvalid_r  <= 1'b0;
            bresp_r   <= RESP_OKAY;
            aw_got_r  <= 1'b0;
            w_got_r   <= 1'b0;
            awaddr_r  <= 32'h00000000;
            wdata_r   <= 32'h00000000;
            wstrb_r   <= 4'h0;
        end else begin
            awready_r <= ~aw_got_nxt & ~bvalid_nxt;
            wready_r  <= ~w_got_nxt & ~bvalid_nxt;
            bvalid_r  <= bvalid_nxt;
            aw_got_r  <= aw_got_nxt;
            w_got_r   <= w_got_nxt;
            if (wr_fire) begin
                bresp_r <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end
            if (aw_hs) begin
                awaddr_r <= s_axi_awaddr;
            end
            if (w_hs) begin
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
        end
    end

    // Read channel; a single read is answered one edge after its address is taken.
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            rd_state_r <= RD_IDLE;
            arready_r  <= 1'b0;
            rdata_r    <= 32'h00000000;
            rresp_r    <= RESP_OKAY;
        end else begin
            arready_r <= ~rvalid_nxt;
            case (rd_state_r)
                RD_IDLE: begin
                    if (ar_hs) begin
                        rd_state_r <= RD_RESP;
                        rdata_r    <= rd_word;
                        rresp_r    <= rd_ok ? RESP_OKAY : RESP_SLVERR;
                    end
                end
                RD_RESP: begin
                    if (s_axi_rready) begin
                        rd_state_r <= RD_IDLE;
                    end
                end
                default: begin
                    rd_state_r <= RD_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    // The block does not lock writes while running; software is trusted to stop the modulator first.
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            ctl_hold_r  <= CTL_ONE_RST;
            dt_r        <= DEAD_TIME_RST;
            mpf_r       <= MIN_PULSE_RST;
            dt_locked_r <= 1'b0;
            clk_src_r   <= 1'b0;
        end else begin
            if (wr_ctl & wr_lane0) begin
                ctl_hold_r <= wr_byte;
            end
            if (dt_take) begin
                dt_r        <= wr_byte;
                dt_locked_r <= 1'b1;
            end
            if (wr_mpf & wr_lane0) begin
                mpf_r <= wr_byte;
            end
            if (wr_src & wr_lane0) begin
                clk_src_r <= wr_byte[0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Input clock tick, reload rate and divider
    // ------------------------------------------------------------------
    wire       in_tick   = clk_src_r ? (external_modulator_clock_in & ~ext_d_r) : 1'b1;
    wire [1:0] rate_hold = ctl_hold_r[RATE_LSB +: 2];
    wire [1:0] div_hold  = ctl_hold_r[DIV_LSB +: 2];
    wire       indep     = ctl_hold_r[INDEP_BIT];
    wire [2:0] rate_max  = {rate_work_r == 2'h3, rate_work_r[1], |rate_work_r};
    wire [2:0] div_max   = {div_work_r == 2'h3, div_work_r[1], |div_work_r};
    wire       rl_hit    = period_end & (rl_cnt_r == rate_max);
    wire       dv_hit    = in_tick & (div_cnt_r == div_max);
    wire       do_copy   = rl_hit & values_ready;

    // The rate compare above uses the old working rate, so a new rate starts with the next period.
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            ext_d_r     <= 1'b0;
            rate_work_r <= CTL_ONE_RST[RATE_LSB +: 2];
            div_work_r  <= CTL_ONE_RST[DIV_LSB +: 2];
            rl_cnt_r    <= 3'h0;
            div_cnt_r   <= 3'h0;
            reload_r    <= 1'b0;
            load_r      <= 1'b0;
            presc_r     <= 1'b0;
        end else begin
            ext_d_r  <= external_modulator_clock_in;
            reload_r <= rl_hit;
            load_r   <= do_copy;
            presc_r  <= dv_hit;
            if (period_end) begin
                rate_work_r <= rate_hold;
                rl_cnt_r    <= rl_hit ? 3'h0 : rl_cnt_r + 3'h1;
            end
            if (do_copy) begin
                div_work_r <= div_hold;
            end
            if (in_tick) begin
                div_cnt_r <= dv_hit ? 3'h0 : div_cnt_r + 3'h1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Minimum pulse filter, one per channel
    // ------------------------------------------------------------------
    // Filtering the requested levels ahead of the dead time keeps the dead-time gap itself intact.
    wire [8:0]  dt_eff = (dt_r == 8'h00) ? DEAD_TIME_MAX : {1'b0, dt_r};
    wire [9:0]  pulse_sum = {1'b0, dt_eff} + {2'h0, mpf_r};
    wire [12:0] min_w = {3'h0, pulse_sum} << div_work_r;

    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_filt
            wire differs = duty_level[gi] != filt_r[gi];
            wire adopt   = differs & in_tick & (fcnt_r[gi] + 13'h0001 >= min_w);
            // A request must persist for the full width before the output level follows it.
            always_ff @(posedge ref_clk) begin
                if (!rst_b) begin
                    filt_r[gi] <= 1'b0;
                    fcnt_r[gi] <= 13'h0000;
                end else begin
                    if (!differs || adopt) begin
                        fcnt_r[gi] <= 13'h0000;
                    end else if (in_tick) begin
                        fcnt_r[gi] <= fcnt_r[gi] + 13'h0001;
                    end
                    if (adopt) begin
                        filt_r[gi] <= duty_level[gi];
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Dead time and polarity, one per pair
    // ------------------------------------------------------------------
    generate
        for (gi = 0; gi < 3; gi++) begin : g_pair
            wire edge_seen = filt_r[2*gi] != last_r[gi];
            wire gap       = dcnt_r[gi] != 9'h000;
            wire inv       = ctl_hold_r[PAIR0_INV_BIT + gi];
            wire hi_lvl    = indep ? filt_r[2*gi] : (last_r[gi] & ~gap);
            wire lo_lvl    = indep ? filt_r[2*gi+1] : (~last_r[gi] & ~gap);
            // Dead time counts undivided ticks so the divider never stretches the gap.
            always_ff @(posedge ref_clk) begin
                if (!rst_b) begin
                    last_r[gi]   <= 1'b0;
                    dcnt_r[gi]   <= 9'h000;
                    pwm_r[2*gi]   <= 1'b0;
                    pwm_r[2*gi+1] <= 1'b0;
                end else begin
                    last_r[gi] <= filt_r[2*gi];
                    if (edge_seen && !indep) begin
                        dcnt_r[gi] <= dt_eff;
                    end else if (gap && in_tick) begin
                        dcnt_r[gi] <= dcnt_r[gi] - 9'h001;
                    end
                    pwm_r[2*gi]   <= hi_lvl ^ inv;
                    pwm_r[2*gi+1] <= lo_lvl ^ inv;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign s_axi_awready   = awready_r;
    assign s_axi_wready    = wready_r;
    assign s_axi_bvalid    = bvalid_r;
    assign s_axi_bresp     = bresp_r;
    assign s_axi_arready   = arready_r;
    assign s_axi_rvalid    = rd_state_r == RD_RESP;
    assign s_axi_rdata     = rdata_r;
    assign s_axi_rresp     = rresp_r;
    assign pwm_out         = pwm_r;
    assign reload_evt      = reload_r;
    assign load_working    = load_r;
    assign prescale_tick   = presc_r;
    assign working_divider = div_work_r;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    wire edge_seen0 = filt_r[0] != last_r[0];

    reload_from_period_a: assert property (reload_evt |-> $past(period_end))
        else $error("reload without period end");
    rate_latch_a: assert property (period_end |=> rate_work_r == $past(rate_hold))
        else $error("working rate not taken at period end");
    hold_readback_a: assert property (ar_hs && rd_ctl |=> s_axi_rdata[7:0] == $past(ctl_hold_r))
        else $error("control read not from holding value");
    pair_exclusive_a: assert property (!indep && $past(!indep) |->
        !((pwm_r[0] ^ $past(ctl_hold_r[PAIR0_INV_BIT])) && (pwm_r[1] ^ $past(ctl_hold_r[PAIR0_INV_BIT]))))
        else $error("pair outputs both asserted");
    indep_follow_a: assert property (indep |=> pwm_r[1] == ($past(filt_r[1]) ^ $past(ctl_hold_r[2])))
        else $error("independent output mismatch");
    div_copy_a: assert property (!do_copy && !$past(do_copy) |-> $stable(div_work_r))
        else $error("divider changed outside reload");
    load_pulse_a: assert property (rl_hit && values_ready |=> load_working ##1 !load_working)
        else $error("copy pulse missing");
    dt_once_a: assert property (dt_locked_r && wr_dt |=> $stable(dt_r))
        else $error("dead time changed after first write");
    dt_load_a: assert property (edge_seen0 && !indep |=> dcnt_r[0] == $past(dt_eff))
        else $error("dead time count wrong");
    filter_hold_a: assert property ($changed(filt_r[0]) |-> $past(fcnt_r[0]) + 13'h0001 >= $past(min_w))
        else $error("short pulse passed the filter");
    presc_max_a: assert property (presc_r |-> $past(div_cnt_r) == $past(div_max))
        else $error("divider tick at wrong count");

    reload_seen_c: cover property (reload_evt ##[1:40] reload_evt);
    copy_seen_c: cover property (load_working);
    dead_gap_c: cover property (dcnt_r[0] != 9'h000 ##1 dcnt_r[0] == 9'h000);

endmodule // pwm_timing_config

// File: tb/gate_driver_model.sv
// Behavioural model of the gate drivers that sit on the six modulator outputs.
`timescale 1ns/10ps
module gate_driver_model (
    input  wire logic       ref_clk,
    input  wire logic [5:0] pwm_out,
    input  wire logic       pairs_mode,
    output logic [7:0]      shoot_cnt
);
    // A pair driving both switches on shorts the supply rail, so every such cycle in pairs mode is counted.
    logic [7:0] cnt_r = 8'h00;
    assign shoot_cnt = cnt_r;
    always @(posedge ref_clk) begin
        if (pairs_mode && ((&pwm_out[1:0]) || (&pwm_out[3:2]) || (&pwm_out[5:4]))) begin
            cnt_r <= cnt_r + 8'h01;
        end
    end
endmodule // gate_driver_model

// File: tb/testbench.sv
// Self-checking bench for the modulator timing and configuration block.
`timescale 1ns/10ps
module testbench;
    import pwm_timing_config_pkg::*;
    logic ref_clk = 1'b0, rst_b = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
    logic rready = 1'b0, period_end = 1'b0, values_ready = 1'b0, awready, wready, bvalid, arready, rvalid;
    logic reload_evt, load_working, prescale_tick;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
    logic [1:0]  bresp, rresp, working_divider;
    logic [5:0]  duty_level = 6'h00, pwm_out;
    logic [7:0]  shoot_cnt;
    int          fails = 0, n_checks = 0, n_rl = 0, n_ld = 0, n_tick = 0, gap, s_rl = 0, s_ld = 0, s_tk = 0;
    logic        ext_clk = 1'b0, pairs = 1'b1;
    always #2 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        n_rl <= n_rl + int'(reload_evt === 1'b1);
        n_ld <= n_ld + int'(load_working === 1'b1);
        n_tick <= n_tick + int'(prescale_tick === 1'b1);
    end
    pwm_timing_config u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .external_modulator_clock_in(ext_clk),
        .period_end(period_end), .values_ready(values_ready), .duty_level(duty_level), .pwm_out(pwm_out),
        .reload_evt(reload_evt), .load_working(load_working), .prescale_tick(prescale_tick),
        .working_divider(working_divider));
    gate_driver_model u_gates (.ref_clk(ref_clk), .pwm_out(pwm_out), .pairs_mode(pairs), .shoot_cnt(shoot_cnt));
    // ------------------------------------------------------------------
    // Checking and bus tasks
    // ------------------------------------------------------------------
    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Both write channels are offered together; each drops once taken and bready waits for the answer.
    task automatic axi_wr(input logic [31:0] a, input logic [7:0] d, input logic [1:0] er);
        int n;
        @(posedge ref_clk);
        awaddr <= a; wdata <= {24'h0, d}; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        for (n = 0; n < 60 && bvalid !== 1'b1; n++) begin
            @(posedge ref_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end
        if (n == 60) begin fails++; give_verdict(); end
        bready <= 1'b0;
        check({30'h0, bresp}, {30'h0, er});
    endtask
    task automatic axi_rd(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        @(posedge ref_clk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        for (n = 0; n < 60 && rvalid !== 1'b1; n++) begin
            @(posedge ref_clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end
        if (n == 60) begin fails++; give_verdict(); end
        rready <= 1'b0;
        check(rdata, ed);
        check({30'h0, rresp}, {30'h0, er});
    endtask
    // Waits for the shaped outputs to settle, counting cycles in which pair zero is fully off.
    task automatic wait_out(input logic [5:0] e);
        int n;
        gap = 0;
        for (n = 0; n < 1200 && pwm_out !== e; n++) begin
            @(posedge ref_clk);
            if (pwm_out[1:0] === 2'b00) gap++;
        end
        check({26'h0, pwm_out}, {26'h0, e});
    endtask
    task automatic pulse_periods(input int k);
        repeat (k) begin
            @(posedge ref_clk) period_end <= 1'b1;
            @(posedge ref_clk) period_end <= 1'b0;
            repeat (2) @(posedge ref_clk);
        end
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic regs_after_reset();
        axi_rd(CTL_ONE_ADDR, 32'h00, RESP_OKAY);
        axi_rd(DEAD_TIME_ADDR, 32'h01, RESP_OKAY);
        axi_rd(MIN_PULSE_ADDR, 32'h00, RESP_OKAY);
        axi_rd(32'h0000_0010, 32'h00, RESP_SLVERR);
        axi_wr(32'h0000_0010, 8'h5A, RESP_SLVERR);
    endtask
    task automatic dead_time_once();
        axi_wr(DEAD_TIME_ADDR, 8'h05, RESP_OKAY);
        axi_wr(DEAD_TIME_ADDR, 8'h09, RESP_OKAY);
        axi_rd(DEAD_TIME_ADDR, 32'h05, RESP_OKAY);
        axi_wr(MIN_PULSE_ADDR, 8'h02, RESP_OKAY);
        axi_rd(MIN_PULSE_ADDR, 32'h02, RESP_OKAY);
    endtask
    // Independent channels with pair zero inverted, then a runt pulse that must vanish.
    task automatic independent_outputs();
        pairs <= 1'b0;
        axi_wr(CTL_ONE_ADDR, 8'h24, RESP_OKAY);
        duty_level <= 6'h00;
        wait_out(6'h03);
        duty_level <= 6'h01;
        wait_out(6'h02);
        @(posedge ref_clk) duty_level <= 6'h21;
        repeat (3) @(posedge ref_clk);
        duty_level <= 6'h01;
        repeat (30) @(posedge ref_clk);
        check({26'h0, pwm_out}, 32'h02);
    endtask
    // Complementary pairs: a switch of pair zero passes through a five-cycle all-off gap.
    task automatic complementary_dead_time();
        axi_wr(CTL_ONE_ADDR, 8'h00, RESP_OKAY);
        pairs <= 1'b1;
        duty_level <= 6'h00;
        wait_out(6'h2A);
        duty_level <= 6'h01;
        wait_out(6'h29);
        check(gap, 32'd5);
        check({24'h0, shoot_cnt}, 32'h00);
    endtask
    // Every rate and divider code: reload spacing, readback of the holding value and tick rate.
    task automatic rates_and_divider();
        for (int r = 0; r < 4; r++) begin
            values_ready <= 1'b1;
            axi_wr(CTL_ONE_ADDR, {r[1:0], 4'h0, r[1:0]}, RESP_OKAY);
            axi_rd(CTL_ONE_ADDR, {24'h0, r[1:0], 4'h0, r[1:0]}, RESP_OKAY);
            pulse_periods(8);
            check({30'h0, working_divider}, {30'h0, r[1:0]});
            s_rl = n_rl;
            s_ld = n_ld;
            pulse_periods(16);
            check(n_rl - s_rl, 32'd16 >> r);
            check(n_ld - s_ld, 32'd16 >> r);
            @(posedge ref_clk);
            s_tk = n_tick;
            repeat (64) @(posedge ref_clk);
            check(n_tick - s_tk, 32'd64 >> r);
        end
    endtask
    // A second reset reopens the dead time register; a value of 00h must give the longest gap.
    task automatic dead_time_zero();
        @(posedge ref_clk) rst_b <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_b <= 1'b1;
        axi_rd(DEAD_TIME_ADDR, 32'h01, RESP_OKAY);
        axi_wr(DEAD_TIME_ADDR, 8'h00, RESP_OKAY);
        axi_rd(STATUS_ADDR, 32'h80, RESP_OKAY);
        axi_wr(STATUS_ADDR, 8'h00, RESP_SLVERR);
        duty_level <= 6'h00;
        wait_out(6'h2A);
        duty_level <= 6'h01;
        wait_out(6'h29);
        check(gap, 32'd256);
        check({24'h0, shoot_cnt}, 32'h00);
    endtask
    // External input clock: sixteen rising edges at divide-by-one must give sixteen divider ticks.
    task automatic external_ticks();
        axi_wr(CLK_SOURCE_ADDR, 8'h01, RESP_OKAY);
        axi_rd(CLK_SOURCE_ADDR, 32'h01, RESP_OKAY);
        s_tk = n_tick;
        repeat (32) @(posedge ref_clk) ext_clk <= ~ext_clk;
        repeat (4) @(posedge ref_clk);
        check(n_tick - s_tk, 32'd16);
    endtask
    initial begin
        repeat (10) @(posedge ref_clk);
        rst_b <= 1'b1;
        regs_after_reset();
        dead_time_once();
        independent_outputs();
        complementary_dead_time();
        rates_and_divider();
        dead_time_zero();
        external_ticks();
        give_verdict();
    end
endmodule // testbench
